// ==== rtl/pifb_pkg.sv ====
// package: register indices, bit positions, masks and reset values of the flag and enable bank
package pifb_pkg;

    localparam int unsigned NPIN_DEFAULT = 8;

    // register indices on the software port
    localparam logic [1:0] IDX_ENABLE_4  = 2'h0;
    localparam logic [1:0] IDX_STATUS_0  = 2'h1;
    localparam logic [1:0] IDX_REQUEST_1 = 2'h2;
    localparam logic [1:0] IDX_REQUEST_2 = 2'h3;

    localparam logic [7:0] RESET_VALUE   = 8'h00;

    // enable register 4 bit positions
    localparam int unsigned WAVEGEN2_SHUTDOWN_EN_BIT = 7;
    localparam int unsigned WAVEGEN1_SHUTDOWN_EN_BIT = 6;
    localparam int unsigned TIMER5_GATE_EN_BIT       = 5;
    localparam int unsigned TIMER5_OVERFLOW_EN_BIT   = 4;
    localparam int unsigned CAPCMP4_EN_BIT           = 3;
    localparam int unsigned CAPCMP3_EN_BIT           = 2;
    localparam int unsigned CAPCMP2_EN_BIT           = 1;
    localparam int unsigned CAPCMP1_EN_BIT           = 0;

    // status register 0 bit positions
    localparam int unsigned TIMER0_OVERFLOW_FLAG_BIT    = 5;
    localparam int unsigned PIN_CHANGE_SUMMARY_FLAG_BIT = 4;
    localparam int unsigned EXTERNAL_IRQ_FLAG_BIT       = 0;

    // request register 1 bit positions
    localparam int unsigned TIMER1_GATE_FLAG_BIT          = 7;
    localparam int unsigned CONVERSION_DONE_FLAG_BIT      = 6;
    localparam int unsigned UART_RX_NONEMPTY_FLAG_BIT     = 5;
    localparam int unsigned UART_TX_FLAG_BIT              = 4;
    localparam int unsigned SYNC_SERIAL_DONE_FLAG_BIT     = 3;
    localparam int unsigned SYNC_SERIAL_COLLISION_FLAG_BIT = 2;
    localparam int unsigned TIMER2_MATCH_FLAG_BIT         = 1;
    localparam int unsigned TIMER1_OVERFLOW_FLAG_BIT      = 0;

    // request register 2 bit positions
    localparam int unsigned TIMER6_MATCH_FLAG_BIT      = 7;
    localparam int unsigned COMPARATOR2_FLAG_BIT       = 6;
    localparam int unsigned COMPARATOR1_FLAG_BIT       = 5;
    localparam int unsigned NVM_TASK_DONE_FLAG_BIT     = 4;
    localparam int unsigned TIMER4_MATCH_FLAG_BIT      = 1;
    localparam int unsigned OSCILLATOR_ROLLOVER_FLAG_BIT = 0;

    // hardware-set, software-writable bits of each flag register
    localparam logic [7:0] STATUS_0_HS_MASK  = 8'h21;
    localparam logic [7:0] REQUEST_1_HS_MASK = 8'hCF;
    localparam logic [7:0] REQUEST_2_HS_MASK = 8'hF3;

    // request 1 condition whose event is the falling edge (gate closing)
    localparam logic [7:0] REQUEST_1_FALL_MASK = 8'h80;

endpackage

// ==== rtl/pifb_link_if.sv ====
// interface: event and enable wires between the flag bank and the peripheral end
`timescale 1ns/1ps
interface pifb_link_if #(
    parameter int unsigned NPIN = pifb_pkg::NPIN_DEFAULT
);
    logic [7:0]      request_1_evt;
    logic [7:0]      request_2_evt;
    logic            timer0_overflow_evt;
    logic            external_irq_evt;
    logic            uart_rx_nonempty_flag;
    logic            uart_tx_flag;
    logic [NPIN-1:0] per_pin_change_flags;
    logic [7:0]      enable_4_pending;
    logic [7:0]      enable_4;

    modport device (
        input  request_1_evt,
        input  request_2_evt,
        input  timer0_overflow_evt,
        input  external_irq_evt,
        input  uart_rx_nonempty_flag,
        input  uart_tx_flag,
        input  per_pin_change_flags,
        input  enable_4_pending,
        output enable_4
    );

    modport periph (
        output request_1_evt,
        output request_2_evt,
        output timer0_overflow_evt,
        output external_irq_evt,
        output uart_rx_nonempty_flag,
        output uart_tx_flag,
        output per_pin_change_flags,
        output enable_4_pending,
        input  enable_4
    );
endinterface

// ==== rtl/pifb_periph.sv ====
// module: peripheral end, turns conditions and pins into events and per-pin change flags
`timescale 1ns/1ps
module pifb_periph #(
    parameter int unsigned NPIN  = pifb_pkg::NPIN_DEFAULT,
    parameter int unsigned SEL_W = (NPIN > 1) ? $clog2(NPIN) : 1
) (
    input  wire logic             sys_clk,
    input  wire logic             nrst,
    pifb_link_if.periph           link,
    input  wire logic [NPIN-1:0]  pin_in,
    input  wire logic [NPIN-1:0]  pin_rise_mask,
    input  wire logic [NPIN-1:0]  pin_fall_mask,
    input  wire logic [NPIN-1:0]  pin_flag_clear,
    input  wire logic [SEL_W-1:0] external_irq_pin_select,
    input  wire logic [7:0]       request_1_cond,
    input  wire logic [7:0]       request_2_cond,
    input  wire logic             timer0_overflow,
    input  wire logic             uart_rx_nonempty,
    input  wire logic             uart_tx_ready,
    input  wire logic [7:0]       enable_4_pending_in,
    output logic      [7:0]       enable_4_out
);
    import pifb_pkg::*;

    logic [NPIN-1:0] pin_meta_q;
    logic [NPIN-1:0] pin_sync_q;
    logic [NPIN-1:0] pin_prev_q;
    logic [NPIN-1:0] pin_flags_q;
    logic [7:0]      cond_1_prev_q;
    logic [7:0]      cond_2_prev_q;
    logic            timer0_prev_q;
    logic [NPIN-1:0] pin_edge;
    logic            ext_pin_now;
    logic            ext_pin_prev;

    // pins are asynchronous: two flops before any logic looks at them
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pin_meta_q <= '0;
            pin_sync_q <= '0;
            pin_prev_q <= '0;
        end else begin
            pin_meta_q <= pin_in;
            pin_sync_q <= pin_meta_q;
            pin_prev_q <= pin_sync_q;
        end
    end

    assign pin_edge = (pin_sync_q & ~pin_prev_q & pin_rise_mask)
                    | (~pin_sync_q & pin_prev_q & pin_fall_mask); // RL6
    assign ext_pin_now  = pin_sync_q[external_irq_pin_select];
    assign ext_pin_prev = pin_prev_q[external_irq_pin_select];

    // new edge beats a clear in the same cycle
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pin_flags_q <= '0;
        end else begin
            pin_flags_q <= (pin_flags_q & ~pin_flag_clear) | pin_edge; // RL6
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cond_1_prev_q <= '0;
            cond_2_prev_q <= '0;
            timer0_prev_q <= 1'b0;
        end else begin
            cond_1_prev_q <= request_1_cond;
            cond_2_prev_q <= request_2_cond;
            timer0_prev_q <= timer0_overflow;
        end
    end

    // every output leaves from a flop; events are one-cycle pulses
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            link.request_1_evt         <= '0;
            link.request_2_evt         <= '0;
            link.timer0_overflow_evt   <= 1'b0;
            link.external_irq_evt      <= 1'b0;
            link.uart_rx_nonempty_flag <= 1'b0;
            link.uart_tx_flag          <= 1'b0;
            link.per_pin_change_flags  <= '0;
            link.enable_4_pending      <= '0;
            enable_4_out               <= '0;
        end else begin
            // gate closing is a falling edge, the rest are rising
            link.request_1_evt <= (request_1_cond ^ cond_1_prev_q)
                                & (request_1_cond ^ REQUEST_1_FALL_MASK)
                                & REQUEST_1_HS_MASK; // RL9
            link.request_2_evt <= request_2_cond & ~cond_2_prev_q & REQUEST_2_HS_MASK;
            link.timer0_overflow_evt   <= timer0_overflow & ~timer0_prev_q;
            link.external_irq_evt      <= ext_pin_now & ~ext_pin_prev; // RL7
            link.uart_rx_nonempty_flag <= uart_rx_nonempty; // RL11
            link.uart_tx_flag          <= uart_tx_ready;
            link.per_pin_change_flags  <= pin_flags_q;
            link.enable_4_pending      <= enable_4_pending_in;
            enable_4_out               <= link.enable_4;
        end
    end

endmodule

// ==== rtl/pifb_device.sv ====
// module: peripheral interrupt flag and enable bank with software register port
//
// Contract
// (RL1) peripheral requests need master enable set too
// (RL2) enable register bits: wavegen, timer5, capture/compare
// (RL3) flags set regardless of their enables
// (RL4) all bits reset to zero
// (RL5) timer0 overflow flag sticky until software clears
// (RL6) pin change summary reads OR of flags
// (RL7) external interrupt flag sticky, software clears
// (RL8) unimplemented bits read zero, ignore writes
// (RL9) timer1 gate closing sets its flag
// (RL10) conversion complete sets its flag
// (RL11) uart receive flag mirrors buffer nonempty
// (RL12) serial transfer complete flag, software clears
// (RL13) serial bus collision flag, software clears
// (RL14) timer2 period match flag, software clears
// (RL15) timer1 overflow flag, software clears
// (RL16) timer6 period match flag, software clears
// (RL17) comparator 2 and 1 set their flags
// (RL18) memory programming done sets its flag
// (RL19) timer4 period match flag, software clears
// (RL20) oscillator rollover sets its flag
// (RL21) software clears flags before enabling
// (RL22) request is OR of flag AND enable
// (RL23) write one sets, zero clears, hardware wins
`timescale 1ns/1ps
module pifb_device #(
    parameter int unsigned NPIN = pifb_pkg::NPIN_DEFAULT
) (
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    pifb_link_if.device     link,
    input  wire logic [1:0] reg_idx,
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic [7:0] status_0_enable,
    input  wire logic [7:0] request_1_enable,
    input  wire logic [7:0] request_2_enable,
    input  wire logic       peripheral_master_enable,
    output logic            periph_irq_req,
    output logic      [7:0] irq_enable_4
);
    import pifb_pkg::*;

    logic [7:0] enable_4_q;
    logic [7:0] status_0_q;
    logic [7:0] request_1_q;
    logic [7:0] request_2_q;
    logic [7:0] status_0_d;
    logic [7:0] request_1_d;
    logic [7:0] request_2_d;
    logic [7:0] status_0_evt;
    logic [7:0] status_0_view;
    logic [7:0] request_1_view;
    logic [7:0] request_2_view;
    logic [7:0] read_mux;
    logic       any_request;
    logic       pin_change_summary_flag;
    logic       wr_enable_4;
    logic       wr_status_0;
    logic       wr_request_1;
    logic       wr_request_2;

    // write strobes per register
    always_comb begin
        wr_enable_4  = 1'b0;
        wr_status_0  = 1'b0;
        wr_request_1 = 1'b0;
        wr_request_2 = 1'b0;
        if (reg_wr && reg_idx == IDX_ENABLE_4) begin
            wr_enable_4 = 1'b1;
        end else if (reg_wr && reg_idx == IDX_STATUS_0) begin
            wr_status_0 = 1'b1;
        end else if (reg_wr && reg_idx == IDX_REQUEST_1) begin
            wr_request_1 = 1'b1;
        end else if (reg_wr && reg_idx == IDX_REQUEST_2) begin
            wr_request_2 = 1'b1;
        end
    end

    // plain read/write enables
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            enable_4_q <= RESET_VALUE; // RL4
        end else if (wr_enable_4) begin
            enable_4_q <= reg_wdata; // RL2
        end
    end

    // gather the status 0 hardware events into their bit places
    always_comb begin
        status_0_evt = 8'h00;
        status_0_evt[TIMER0_OVERFLOW_FLAG_BIT] = link.timer0_overflow_evt; // RL5
        status_0_evt[EXTERNAL_IRQ_FLAG_BIT]    = link.external_irq_evt; // RL7
    end

    // sticky flags: an event in the clearing cycle is kept, set wins
    always_comb begin
        status_0_d = status_0_q;
        if (wr_status_0) begin
            status_0_d = reg_wdata; // RL23
        end
        status_0_d = (status_0_d | status_0_evt) & STATUS_0_HS_MASK; // RL3 RL8
    end

    always_comb begin
        request_1_d = request_1_q;
        if (wr_request_1) begin
            request_1_d = reg_wdata; // RL23
        end
        // gate, conversion, serial done, collision, timer2, timer1
        request_1_d = (request_1_d | link.request_1_evt) & REQUEST_1_HS_MASK; // RL3 RL9 RL10
    end

    always_comb begin
        request_2_d = request_2_q;
        if (wr_request_2) begin
            request_2_d = reg_wdata; // RL23
        end
        // timer6, comparators, memory, timer4, oscillator
        request_2_d = (request_2_d | link.request_2_evt) & REQUEST_2_HS_MASK; // RL8 RL17 RL18 RL20
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            status_0_q <= RESET_VALUE; // RL4
        end else begin
            status_0_q <= status_0_d; // RL5 RL7
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            request_1_q <= RESET_VALUE; // RL4
        end else begin
            request_1_q <= request_1_d; // RL12 RL13 RL14 RL15
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            request_2_q <= RESET_VALUE; // RL4
        end else begin
            request_2_q <= request_2_d; // RL16 RL19
        end
    end

    // summary bit is live, no storage, so it drops as soon as pin flags clear
    assign pin_change_summary_flag = |link.per_pin_change_flags; // RL6

    // software-visible images; level bits are merged in here, not latched
    always_comb begin
        status_0_view = status_0_q;
        status_0_view[PIN_CHANGE_SUMMARY_FLAG_BIT] = pin_change_summary_flag; // RL6
        request_1_view = request_1_q;
        request_1_view[UART_RX_NONEMPTY_FLAG_BIT] = link.uart_rx_nonempty_flag; // RL11
        request_1_view[UART_TX_FLAG_BIT]          = link.uart_tx_flag;
        request_2_view = request_2_q;
    end

    always_comb begin
        read_mux = 8'h00;
        if (reg_idx == IDX_ENABLE_4) begin
            read_mux = enable_4_q;
        end else if (reg_idx == IDX_STATUS_0) begin
            read_mux = status_0_view;
        end else if (reg_idx == IDX_REQUEST_1) begin
            read_mux = request_1_view;
        end else if (reg_idx == IDX_REQUEST_2) begin
            read_mux = request_2_view;
        end
    end

    // read data holds until the next read strobe
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= RESET_VALUE;
        end else if (reg_rd) begin
            reg_rdata <= read_mux;
        end
    end

    // each source requests only when flag and own enable agree
    assign any_request = |(status_0_view & status_0_enable)
                       | |(request_1_view & request_1_enable)
                       | |(request_2_view & request_2_enable)
                       | |(link.enable_4_pending & enable_4_q); // RL22

    // one flop of latency on the request; the cpu side samples a level anyway
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            periph_irq_req <= 1'b0;
        end else begin
            periph_irq_req <= peripheral_master_enable & any_request; // RL1
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            irq_enable_4 <= RESET_VALUE;
            link.enable_4 <= RESET_VALUE;
        end else begin
            irq_enable_4  <= enable_4_q; // RL2
            link.enable_4 <= enable_4_q;
        end
    end

endmodule

// ==== tb/pifb_checker.sv ====
// checker: link-level assertions between the two ends of the flag bank
`timescale 1ns/1ps
module pifb_checker #(
    parameter int unsigned NPIN = 8
) (
    input wire logic            sys_clk,
    input wire logic            nrst,
    input wire logic [7:0]      request_1_evt,
    input wire logic [7:0]      request_2_evt,
    input wire logic            timer0_overflow_evt,
    input wire logic            external_irq_evt,
    input wire logic [NPIN-1:0] per_pin_change_flags,
    input wire logic [7:0]      enable_4
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    // first edge after reset release
    sequence s_released;
        $rose(nrst);
    endsequence

    sequence s_evt_quiet;
        request_1_evt == 8'h00 && request_2_evt == 8'h00 && !timer0_overflow_evt
            && !external_irq_evt;
    endsequence

    AST_REQ1_LEVEL_BITS: assert property (request_1_evt[5:4] == 2'h0)
        else $error("level-only request bits pulsed on the link");
    AST_REQ2_UNIMPL: assert property (request_2_evt[3:2] == 2'h0)
        else $error("unimplemented request bits pulsed on the link");
    // an edge detector cannot fire the same bit twice in a row
    AST_REQ1_PULSE: assert property ((|request_1_evt) |=>
        (request_1_evt & $past(request_1_evt)) == 8'h00)
        else $error("request 1 event wider than one cycle");
    AST_REQ2_PULSE: assert property ((|request_2_evt) |=>
        (request_2_evt & $past(request_2_evt)) == 8'h00)
        else $error("request 2 event wider than one cycle");
    AST_T0_PULSE: assert property (timer0_overflow_evt |=> !timer0_overflow_evt)
        else $error("timer0 overflow event wider than one cycle");
    AST_EXT_PULSE: assert property (external_irq_evt |=> !external_irq_evt)
        else $error("external event wider than one cycle");
    AST_EVT_RESET: assert property (s_released |-> s_evt_quiet)
        else $error("event active right after reset");
    AST_LINK_RESET: assert property (s_released |->
        enable_4 == 8'h00 && per_pin_change_flags == '0)
        else $error("link levels not zero after reset");
endmodule

// ==== tb/peripheral_irq_flag_enable_bank_tb_top.sv ====
// testbench: device and peripheral ends joined by the link, checked at the register port
`timescale 1ns/1ps
module peripheral_irq_flag_enable_bank_tb_top;
    import pifb_pkg::*;
    logic       sys_clk = 1'b0;
    logic       nrst = 1'b0;
    logic [7:0] pin_in, pin_rise_mask, pin_fall_mask, pin_flag_clear;
    logic [2:0] external_irq_pin_select;
    logic [7:0] request_1_cond, request_2_cond, enable_4_pending_in, enable_4_out;
    logic       timer0_overflow, uart_rx_nonempty, uart_tx_ready;
    logic [1:0] reg_idx;
    logic       reg_wr, reg_rd, peripheral_master_enable, periph_irq_req, rd_seen;
    logic [7:0] reg_wdata, reg_rdata, irq_enable_4;
    logic [7:0] status_0_enable, request_1_enable, request_2_enable;
    logic [7:0] expq [$];
    logic [7:0] hsm [4] = '{8'h00, STATUS_0_HS_MASK, REQUEST_1_HS_MASK, REQUEST_2_HS_MASK};
    int         n_errors = 0;
    int         compares = 0;
    integer     seed = 93;

    pifb_link_if #(.NPIN(8)) link ();
    pifb_periph #(.NPIN(8)) u_pifb_periph (.sys_clk, .nrst, .link(link), .pin_in,
        .pin_rise_mask, .pin_fall_mask, .pin_flag_clear, .external_irq_pin_select,
        .request_1_cond, .request_2_cond, .timer0_overflow, .uart_rx_nonempty,
        .uart_tx_ready, .enable_4_pending_in, .enable_4_out);
    pifb_device #(.NPIN(8)) u_pifb_device (.sys_clk, .nrst, .link(link), .reg_idx,
        .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .status_0_enable, .request_1_enable,
        .request_2_enable, .peripheral_master_enable, .periph_irq_req, .irq_enable_4);
    pifb_checker #(.NPIN(8)) u_pifb_checker (.sys_clk, .nrst,
        .request_1_evt(link.request_1_evt), .request_2_evt(link.request_2_evt),
        .timer0_overflow_evt(link.timer0_overflow_evt),
        .external_irq_evt(link.external_irq_evt),
        .per_pin_change_flags(link.per_pin_change_flags), .enable_4(link.enable_4));

    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: request line %b expected %b", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    task automatic wr(input logic [1:0] idx, input logic [7:0] d);
        @(negedge sys_clk);
        reg_idx = idx;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge sys_clk);
        reg_wr = 1'b0;
    endtask

    task automatic rd(input logic [1:0] idx, input logic [7:0] e);
        @(negedge sys_clk);
        reg_idx = idx;
        reg_rd = 1'b1;
        expq.push_back(e);
        @(negedge sys_clk);
        reg_rd = 1'b0;
    endtask

    task automatic tog(input int k);
        if (k < 8) begin
            request_1_cond[k] = ~request_1_cond[k];
        end else begin
            request_2_cond[k-8] = ~request_2_cond[k-8];
        end
    endtask

    task automatic print_verdict;
        $display("compares %0d errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // read data is registered, so it is compared one cycle after the strobe
    always @(posedge sys_clk) rd_seen <= reg_rd;
    always @(negedge sys_clk) begin
        if (rd_seen === 1'b1) begin
            chk8(reg_rdata, expq.pop_front());
        end
    end

    initial begin
        repeat (4000) @(posedge sys_clk);
        n_errors++;
        print_verdict();
    end

    initial begin
        int         k;
        logic [1:0] idx;
        logic [7:0] v;
        logic [2:0] p;
        {pin_in, pin_rise_mask, pin_fall_mask, pin_flag_clear} = '0;
        {external_irq_pin_select, timer0_overflow, uart_rx_nonempty, uart_tx_ready} = '0;
        {reg_idx, reg_wr, reg_rd, reg_wdata, peripheral_master_enable} = '0;
        {status_0_enable, request_1_enable, request_2_enable, enable_4_pending_in} = '0;
        request_2_cond = 8'h00;
        request_1_cond = 8'h80;
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        nrst = 1'b1;
        for (k = 0; k < 4; k++) rd(2'(k), 8'h00);
        chk8(irq_enable_4, 8'h00);
        v = 8'($random(seed));
        wr(IDX_ENABLE_4, v);
        rd(IDX_ENABLE_4, v);
        tick(2);
        chk8(irq_enable_4, v);
        chk8(enable_4_out, v);
        for (k = 1; k < 4; k++) begin
            wr(2'(k), 8'hFF);
            rd(2'(k), hsm[k]);
            wr(2'(k), 8'h00);
            rd(2'(k), 8'h00);
        end
        // gate flag fires on the falling edge, so its condition idles high
        for (k = 0; k < 16; k++) begin
            idx = (k < 8) ? IDX_REQUEST_1 : IDX_REQUEST_2;
            if (hsm[idx][k%8]) begin
                tog(k);
                tick(3);
                rd(idx, 8'h01 << (k % 8));
                wr(idx, 8'h00);
                tog(k);
                tick(3);
                rd(idx, 8'h00);
            end
        end
        timer0_overflow = 1'b1;
        tick(3);
        timer0_overflow = 1'b0;
        tick(2);
        rd(IDX_STATUS_0, 8'h20);
        wr(IDX_STATUS_0, 8'h00);
        rd(IDX_STATUS_0, 8'h00);
        request_1_cond[0] = 1'b1;
        wr(IDX_REQUEST_1, 8'h00);
        rd(IDX_REQUEST_1, 8'h01);
        wr(IDX_REQUEST_1, 8'h00);
        request_1_cond[0] = 1'b0;
        wr(IDX_REQUEST_2, 8'h02);
        request_2_enable = 8'h02;
        tick(3);
        chk1(periph_irq_req, 1'b0);
        peripheral_master_enable = 1'b1;
        tick(3);
        chk1(periph_irq_req, 1'b1);
        request_2_enable = 8'h00;
        tick(3);
        chk1(periph_irq_req, 1'b0);
        wr(IDX_ENABLE_4, 8'h10);
        enable_4_pending_in = 8'h10;
        tick(4);
        chk1(periph_irq_req, 1'b1);
        enable_4_pending_in = 8'hEF;
        tick(4);
        chk1(periph_irq_req, 1'b0);
        wr(IDX_REQUEST_2, 8'h00);
        uart_rx_nonempty = 1'b1;
        uart_tx_ready = 1'b1;
        tick(3);
        rd(IDX_REQUEST_1, 8'h30);
        uart_rx_nonempty = 1'b0;
        tick(3);
        rd(IDX_REQUEST_1, 8'h10);
        uart_tx_ready = 1'b0;
        p = 3'($random(seed));
        pin_rise_mask[p] = 1'b1;
        external_irq_pin_select = p;
        pin_in[p] = 1'b1;
        tick(8);
        rd(IDX_STATUS_0, 8'h11);
        pin_flag_clear = 8'hFF;
        tick(2);
        pin_flag_clear = 8'h00;
        pin_in[p] = 1'b0;
        tick(8);
        rd(IDX_STATUS_0, 8'h01);
        wr(IDX_STATUS_0, 8'h00);
        rd(IDX_STATUS_0, 8'h00);
        // request 2 flags and enable 4 set, then a reset in mid-run must clear them all
        wr(IDX_REQUEST_2, 8'hF3);
        wr(IDX_ENABLE_4, 8'hFF);
        nrst = 1'b0;
        tick(2);
        nrst = 1'b1;
        for (k = 0; k < 4; k++) rd(2'(k), 8'h00);
        chk8(irq_enable_4, 8'h00);
        chk8(enable_4_out, 8'h00);
        tick(4);
        print_verdict();
    end
endmodule
